// ### shared/sdwb_regs.svh
// Constants for the write burst link: encodings, sizes, register offsets and timing counts.
`ifndef SDWB_REGS_SVH
`define SDWB_REGS_SVH
`define SDWB_BURST_FIXED8 2'h0
`define SDWB_BURST_PERCMD 2'h1
`define SDWB_BURST_FIXED4 2'h2
`define SDWB_BEATS_FULL 4'h8
`define SDWB_BEATS_CHOP 4'h4
`define SDWB_TAIL_FULL 6'h4
`define SDWB_TAIL_CHOP 6'h2
`define SDWB_CWL_LOWEST 5'h09
`define SDWB_SPACING_FORBIDDEN 6'h05
`define SDWB_SPACING_LONG 6'h06
`define SDWB_CLK_DIV 4'h4
`define SDWB_ROW_BITS 4
`define SDWB_MEM_WORDS 16
`define SDWB_FIFO_DEPTH 32
`define SDWB_FIFO_AW 5
// Controller register offsets.
`define SDWB_REG_CONFIG 4'h0
`define SDWB_REG_CMD 4'h1
`define SDWB_REG_DATA 4'h2
`define SDWB_REG_STATUS 4'h3
`define SDWB_REG_TIMING 4'h4
`endif

// ### shared/sdwb_pkg.sv
// Types shared by both ends of the write burst link.
package sdwb_pkg;
  typedef enum logic [1:0] {
    SDWB_MODE_FIXED8 = 2'b00,
    SDWB_MODE_PERCMD = 2'b01,
    SDWB_MODE_FIXED4 = 2'b10
  } sdwb_burst_mode_t;
  typedef enum logic [2:0] {
    SDWB_DEV_IDLE = 3'b000,
    SDWB_DEV_LAT = 3'b001,
    SDWB_DEV_DATA = 3'b010,
    SDWB_DEV_RECOV = 3'b011
  } sdwb_dev_state_t;
  typedef enum logic [2:0] {
    SDWB_HOST_IDLE = 3'b000,
    SDWB_HOST_CMD = 3'b001,
    SDWB_HOST_WAIT = 3'b010,
    SDWB_HOST_DATA = 3'b011,
    SDWB_HOST_GAP = 3'b100
  } sdwb_host_state_t;
endpackage : sdwb_pkg

// ### shared/sdwb_link_if.sv
// Link between the memory controller and the memory device.
`timescale 1ns/10ps
interface sdwb_link_if;
  logic link_clk;
  logic wr_cmd;
  logic auto_precharge_bit;
  logic burst_chop_select_bit;
  logic [3:0] bank;
  logic [3:0] col;
  logic [15:0] dq;
  logic [1:0] byte_mask_n;
  logic strobe;
  modport host (output link_clk, wr_cmd, auto_precharge_bit, burst_chop_select_bit, bank, col, dq,
    byte_mask_n, strobe);
  modport dev (input link_clk, wr_cmd, auto_precharge_bit, burst_chop_select_bit, bank, col, dq,
    byte_mask_n, strobe);
endinterface : sdwb_link_if

// ### core/sdwb_fifo.sv
// Word FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module sdwb_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ptr != rd_ptr;
  assign o_out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= i_in_data;
  end
endmodule : sdwb_fifo

// ### core/sdwb_host.sv
// Memory controller end: issues write commands and drives burst data.
`timescale 1ns/10ps
`include "sdwb_regs.svh"
module sdwb_host
  import sdwb_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Link
  sdwb_link_if.host link
);
  // ==========================================================
  // Registers
  logic [1:0] burst_mode;
  logic dm_enable;
  logic dbi_enable;
  logic two_clk_pre;
  logic [4:0] additive_latency;
  logic [4:0] column_write_latency;
  logic [5:0] column_cmd_spacing;
  logic [5:0] write_recovery_time;
  logic [31:0] rdata;
  logic cfg_error;
  logic [7:0] cmd_count;
  sdwb_host_state_t state;
  logic [5:0] cnt;
  logic [3:0] beat;
  logic [3:0] beats;
  logic [2:0] div;
  logic lclk;
  logic cmd_ap;
  logic cmd_bc;
  logic [7:0] cmd_addr;
  // Command FIFO holds {ap, chop_sel, bank, col}; data FIFO holds {mask_n, data}.
  logic cq_valid;
  logic [9:0] cq_data;
  logic dq_valid;
  logic [17:0] dq_data;
  wire cq_ready;
  wire dq_ready;
  wire wr_cfg = i_wr && (i_addr == `SDWB_REG_CONFIG);
  wire wr_cmdr = i_wr && (i_addr == `SDWB_REG_CMD);
  wire wr_data = i_wr && (i_addr == `SDWB_REG_DATA);
  wire wr_tim = i_wr && (i_addr == `SDWB_REG_TIMING);
  wire [5:0] total_write_latency = 6'(additive_latency) + 6'(column_write_latency);
  wire chop_now = (burst_mode == `SDWB_BURST_FIXED4) ||
                  ((burst_mode == `SDWB_BURST_PERCMD) && !cmd_bc);
  wire [5:0] eff_spacing = (two_clk_pre && column_cmd_spacing == `SDWB_SPACING_FORBIDDEN) ?
                           `SDWB_SPACING_LONG : column_cmd_spacing;
  // Recovery plus burst tail, counted in link clocks after the last data pair.
  wire [5:0] recov_tail = write_recovery_time +
                          ((burst_mode == `SDWB_BURST_FIXED4) ? `SDWB_TAIL_CHOP : `SDWB_TAIL_FULL);
  wire cfg_bad = (dm_enable && dbi_enable) ||
                 (two_clk_pre && column_write_latency <= `SDWB_CWL_LOWEST);
  wire lclk_rise = (div == 3'(`SDWB_CLK_DIV / 2 - 1)) && !lclk;
  wire pop_cmd = (state == SDWB_HOST_IDLE) && lclk_rise && !cfg_error;
  wire pop_beat = (state == SDWB_HOST_DATA) && lclk_rise;

  sdwb_fifo #(.WIDTH(10), .DEPTH(`SDWB_FIFO_DEPTH), .AW(`SDWB_FIFO_AW)) u_cmdq (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_in_valid(wr_cmdr), .i_in_data(i_wdata[9:0]), .o_in_ready(cq_ready),
    .o_out_valid(cq_valid), .o_out_data(cq_data), .i_out_ready(pop_cmd));
  sdwb_fifo #(.WIDTH(18), .DEPTH(`SDWB_FIFO_DEPTH), .AW(`SDWB_FIFO_AW)) u_dataq (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_in_valid(wr_data), .i_in_data(i_wdata[17:0]), .o_in_ready(dq_ready),
    .o_out_valid(dq_valid), .o_out_data(dq_data), .i_out_ready(pop_beat && beat[0] == 1'b0));

  // ==========================================================
  // Register access
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      burst_mode <= `SDWB_BURST_FIXED8;
      dm_enable <= 1'b0;
      dbi_enable <= 1'b0;
      two_clk_pre <= 1'b0;
      additive_latency <= 5'h00;
      column_write_latency <= `SDWB_CWL_LOWEST;
      column_cmd_spacing <= `SDWB_SPACING_LONG;
      write_recovery_time <= 6'h0c;
      rdata <= 32'h0;
      cfg_error <= 1'b0;
    end
    else
    begin
      cfg_error <= cfg_bad;
      if (wr_cfg)
      begin
        burst_mode <= i_wdata[1:0];
        dm_enable <= i_wdata[2];
        dbi_enable <= i_wdata[3];
        two_clk_pre <= i_wdata[4];
      end
      if (wr_tim)
      begin
        additive_latency <= i_wdata[4:0];
        column_write_latency <= i_wdata[9:5];
        column_cmd_spacing <= i_wdata[15:10];
        write_recovery_time <= i_wdata[21:16];
      end
      if (i_rd)
        rdata <= {14'h0, cmd_count, 3'(state), cfg_error, cq_ready, dq_ready, cq_valid, dq_valid, 2'(burst_mode)};
    end
  end
  assign o_rdata = rdata;

  // ==========================================================
  // Link clock divider and command sequencer
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      div <= 3'h0;
      lclk <= 1'b0;
      state <= SDWB_HOST_IDLE;
      cnt <= 6'h0;
      beat <= 4'h0;
      beats <= 4'h0;
      cmd_ap <= 1'b0;
      cmd_bc <= 1'b1;
      cmd_addr <= 8'h0;
      cmd_count <= 8'h0;
      link.wr_cmd <= 1'b0;
      link.dq <= 16'h0;
      link.byte_mask_n <= 2'h3;
      link.strobe <= 1'b0;
    end
    else
    begin
      div <= (div == 3'(`SDWB_CLK_DIV / 2 - 1)) ? 3'h0 : div + 3'h1;
      if (div == 3'(`SDWB_CLK_DIV / 2 - 1))
        lclk <= !lclk;
      if (lclk_rise)
      begin
        link.wr_cmd <= 1'b0;
        case (state)
          SDWB_HOST_IDLE:
            if (cq_valid && !cfg_error)
            begin
              {cmd_ap, cmd_bc, cmd_addr} <= cq_data;
              link.wr_cmd <= 1'b1;
              cmd_count <= cmd_count + 8'h1;
              state <= SDWB_HOST_WAIT;
              // The preamble only moves the strobe; data always starts after the full latency.
              cnt <= total_write_latency;
            end
          SDWB_HOST_WAIT:
            if (cnt <= 6'h1)
            begin
              state <= SDWB_HOST_DATA;
              beat <= 4'h0;
              beats <= chop_now ? `SDWB_BEATS_CHOP : `SDWB_BEATS_FULL;
            end
            else
            begin
              cnt <= cnt - 6'h1;
              link.strobe <= (cnt <= (two_clk_pre ? 6'h3 : 6'h2)) ? !link.strobe : 1'b0;
            end
          SDWB_HOST_DATA:
          begin
            // Two beats per link clock: one data word covers the pair; the mask rides with it.
            link.dq <= dq_valid ? dq_data[15:0] : 16'h0;
            link.byte_mask_n <= (dq_valid && !dbi_enable) ? dq_data[17:16] : 2'h3;
            link.strobe <= !link.strobe;
            beat <= beat + 4'h2;
            if (beat + 4'h2 >= beats)
            begin
              state <= SDWB_HOST_GAP;
              cnt <= (recov_tail > eff_spacing) ? recov_tail : eff_spacing;
            end
          end
          SDWB_HOST_GAP:
          begin
            link.strobe <= 1'b0;
            if (cnt <= 6'h1)
              state <= SDWB_HOST_IDLE;
            else
              cnt <= cnt - 6'h1;
          end
          default:
            state <= SDWB_HOST_IDLE;
        endcase
      end
    end
  end
  assign link.link_clk = lclk;
  assign link.auto_precharge_bit = cmd_ap;
  assign link.burst_chop_select_bit = cmd_bc;
  assign link.bank = cmd_addr[7:4];
  assign link.col = cmd_addr[3:0];
endmodule : sdwb_host

// ### core/sdwb_dev.sv
// Memory device end: write burst capture, byte masking and auto precharge.
`timescale 1ns/10ps
`include "sdwb_regs.svh"
module sdwb_dev
  import sdwb_pkg::*;
#(
  parameter int DQ_WIDTH = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Mode settings
  input wire logic [1:0] i_burst_mode,
  input wire logic i_dm_enable,
  input wire logic i_dbi_enable,
  input wire logic i_crc_enable,
  input wire logic i_two_clk_pre,
  input wire logic [4:0] i_additive_latency,
  input wire logic [4:0] i_column_write_latency,
  input wire logic [5:0] i_write_recovery_time,
  // Link
  sdwb_link_if.dev link,
  // Status
  output logic [15:0] o_bank_open,
  output logic o_busy,
  output logic o_crc_persistent,
  output logic [15:0] o_last_word
);
  // ==========================================================
  // Link sampling: three flops, a change counts once the last two agree.
  logic [2:0] clk_s;
  logic [2:0] cmd_s;
  logic clk_q;
  wire clk_stable = clk_s[1] == clk_s[2];
  wire lrise = clk_stable && clk_s[1] && !clk_q;
  sdwb_dev_state_t state;
  logic [5:0] cnt;
  logic [3:0] beat;
  logic [3:0] beats;
  logic ap;
  logic [3:0] bank;
  logic [3:0] col;
  logic [15:0] mem [`SDWB_MEM_WORDS];
  logic [15:0] bank_open;
  logic busy;
  logic crc_persistent;
  logic [15:0] last_word;
  wire masking_ok = i_dm_enable && !i_dbi_enable && (DQ_WIDTH != 4);
  wire [5:0] total_write_latency = 6'(i_additive_latency) + 6'(i_column_write_latency);
  wire chop = (i_burst_mode == `SDWB_BURST_FIXED4) ||
              ((i_burst_mode == `SDWB_BURST_PERCMD) && !link.burst_chop_select_bit);
  wire [1:0] lane_keep = masking_ok ? link.byte_mask_n : 2'h3;
  wire [15:0] cur = mem[col + beat[3:1]];
  wire [15:0] merged = {lane_keep[1] ? link.dq[15:8] : cur[15:8],
                        lane_keep[0] ? link.dq[7:0] : cur[7:0]};
  wire storing = (state == SDWB_DEV_DATA) && lrise && (beat < beats);

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clk_s <= 3'h0;
      cmd_s <= 3'h0;
      clk_q <= 1'b0;
    end
    else
    begin
      clk_s <= {clk_s[1:0], link.link_clk};
      cmd_s <= {cmd_s[1:0], link.wr_cmd};
      if (clk_stable)
        clk_q <= clk_s[1];
    end
  end

  // ==========================================================
  // Burst sequencer
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= SDWB_DEV_IDLE;
      cnt <= 6'h0;
      beat <= 4'h0;
      beats <= 4'h0;
      ap <= 1'b0;
      bank <= 4'h0;
      col <= 4'h0;
      bank_open <= 16'hffff;
      busy <= 1'b0;
      crc_persistent <= 1'b0;
      last_word <= 16'h0;
    end
    else
    begin
      crc_persistent <= i_crc_enable && i_dm_enable;
      busy <= state != SDWB_DEV_IDLE;
      if (lrise)
      begin
        case (state)
          SDWB_DEV_IDLE:
            if (cmd_s[1] && cmd_s[2])
            begin
              ap <= link.auto_precharge_bit;
              bank <= link.bank;
              col <= link.col;
              bank_open[link.bank] <= 1'b1;
              beats <= chop ? `SDWB_BEATS_CHOP : `SDWB_BEATS_FULL;
              cnt <= total_write_latency;
              state <= SDWB_DEV_LAT;
            end
          SDWB_DEV_LAT:
            if (cnt <= 6'h1)
            begin
              beat <= 4'h0;
              state <= SDWB_DEV_DATA;
            end
            else
              cnt <= cnt - 6'h1;
          SDWB_DEV_DATA:
          begin
            beat <= beat + 4'h2;
            if (beat + 4'h2 >= `SDWB_BEATS_FULL)
            begin
              cnt <= i_write_recovery_time;
              state <= SDWB_DEV_RECOV;
            end
          end
          SDWB_DEV_RECOV:
            if (cnt <= 6'h1)
            begin
              if (ap)
                bank_open[bank] <= 1'b0;
              state <= SDWB_DEV_IDLE;
            end
            else
              cnt <= cnt - 6'h1;
          default:
            state <= SDWB_DEV_IDLE;
        endcase
      end
      if (storing)
        last_word <= merged;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (storing)
      mem[col + beat[3:1]] <= merged;
  end

  assign o_bank_open = bank_open;
  assign o_busy = busy;
  assign o_crc_persistent = crc_persistent;
  assign o_last_word = last_word;
endmodule : sdwb_dev

// ### test/sdwb_link_chk.sv
// Assertions on the link between the controller and the device.
`timescale 1ns/10ps
module sdwb_link_chk (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Link
  input wire logic link_clk,
  input wire logic wr_cmd,
  input wire logic auto_precharge_bit,
  input wire logic burst_chop_select_bit,
  input wire logic [3:0] bank,
  input wire logic [3:0] col,
  input wire logic [15:0] dq,
  input wire logic [1:0] byte_mask_n,
  input wire logic strobe
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  // ==========
  // Command spacing
  // Cycles since the last command, saturating.
  logic [7:0] gap;
  logic seen;
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      gap <= 8'h00;
      seen <= 1'b0;
    end
    else if ($rose(wr_cmd))
    begin
      gap <= 8'h00;
      seen <= 1'b1;
    end
    else if (gap != 8'hff)
      gap <= gap + 8'h01;
  end
  // ==========
  // Properties
  a_cmd_width: assert property ($rose(wr_cmd) |-> wr_cmd [*4] ##1 !wr_cmd)
    else $error("command pulse is not one link clock long");
  a_fields_held: assert property (wr_cmd && $past(wr_cmd) |->
    $stable({auto_precharge_bit, burst_chop_select_bit, bank, col}))
    else $error("command fields changed during the command");
  a_cmd_on_rise: assert property ($rose(wr_cmd) |-> $rose(link_clk))
    else $error("command does not start on a link clock rise");
  a_cmd_end_rise: assert property ($fell(wr_cmd) |-> $rose(link_clk))
    else $error("command does not end on a link clock rise");
  a_link_high: assert property ($rose(link_clk) |=> link_clk ##1 !link_clk)
    else $error("link clock high phase is not two cycles");
  a_link_low: assert property ($fell(link_clk) |=> !link_clk)
    else $error("link clock low phase is too short");
  a_data_quiet: assert property ($rose(wr_cmd) |=> $stable({dq, byte_mask_n}) [*8])
    else $error("write data moved before the write latency");
  a_cmd_gap: assert property ($rose(wr_cmd) && seen |-> gap >= 8'd23)
    else $error("write commands too close together");
  c_auto_pre: cover property ($rose(wr_cmd) && auto_precharge_bit);
  c_chop_sel: cover property ($rose(wr_cmd) && !burst_chop_select_bit);
  c_masked: cover property (byte_mask_n != 2'h3 && strobe);
endmodule : sdwb_link_chk

// ### test/sdwb_write_burst_control_bench.sv
// Testbench joining the controller and the device over the write link.
`timescale 1ns/10ps
`include "sdwb_regs.svh"
module sdwb_write_burst_control_bench;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [1:0] mode = 2'h0;
  logic mask_en = 1'b0;
  logic inv_en = 1'b0;
  logic crc_en = 1'b0;
  logic pre2 = 1'b0;
  logic [15:0] bank_open;
  logic [15:0] last_word;
  logic busy;
  logic crc_p;
  logic [31:0] rv;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int k;
  sdwb_link_if link();
  always #5 i_core_clk = ~i_core_clk;
  // ==========
  // Both ends and the checker
  sdwb_host u_sdwb_host (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link));
  sdwb_dev u_sdwb_dev (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_burst_mode(mode),
    .i_dm_enable(mask_en), .i_dbi_enable(inv_en), .i_crc_enable(crc_en), .i_two_clk_pre(pre2),
    .i_additive_latency(5'h00), .i_column_write_latency(5'h0a), .i_write_recovery_time(6'h04),
    .link(link), .o_bank_open(bank_open), .o_busy(busy), .o_crc_persistent(crc_p), .o_last_word(last_word));
  sdwb_link_chk u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .link_clk(link.link_clk),
    .wr_cmd(link.wr_cmd), .auto_precharge_bit(link.auto_precharge_bit),
    .burst_chop_select_bit(link.burst_chop_select_bit), .bank(link.bank), .col(link.col),
    .dq(link.dq), .byte_mask_n(link.byte_mask_n), .strobe(link.strobe));
  // ==========
  // Tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
  endtask : rd
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cfg(input logic [1:0] m, input logic d, input logic b, input logic p);
    @(posedge i_core_clk);
    mode <= m;
    mask_en <= d;
    inv_en <= b;
    pre2 <= p;
    wr(`SDWB_REG_CONFIG, {27'h0, p, b, d, m});
  endtask : cfg
  // Sends one command and its data words, then waits for the device to finish.
  task automatic burst(input logic [9:0] c, input int n, input logic [17:0] w0);
    int j;
    wr(`SDWB_REG_CMD, {22'h0, c});
    for (j = 0; j < n; j++)
      wr(`SDWB_REG_DATA, {14'h0, w0 + 18'(j)});
    for (j = 0; j < 400 && busy !== 1'b1; j++)
      @(posedge i_core_clk);
    chk("device started", {31'h0, busy}, 32'h1);
    for (j = 0; j < 2000 && busy !== 1'b0; j++)
      @(posedge i_core_clk);
    chk("device finished", {31'h0, busy}, 32'h0);
    repeat (60) @(posedge i_core_clk);
  endtask : burst
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      test_done();
    end
  end
  // ==========
  // Tests
  initial
  begin
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    wr(`SDWB_REG_TIMING, {10'h0, 6'h04, 6'h06, 5'h0a, 5'h00});
    cfg(2'h0, 1'b0, 1'b0, 1'b0);
    burst({2'b00, 4'h2, 4'h0}, 4, 18'h31100);
    chk("full last word", {16'h0, last_word}, 32'h1103);
    chk("plain bank open", {31'h0, bank_open[2]}, 32'h1);
    burst({2'b11, 4'h5, 4'h8}, 4, 18'h32200);
    chk("auto precharge bank", {31'h0, bank_open[5]}, 32'h0);
    chk("other bank open", {31'h0, bank_open[2]}, 32'h1);
    $display("test full burst done");
    cfg(2'h0, 1'b1, 1'b0, 1'b0);
    burst({2'b01, 4'h2, 4'h0}, 4, 18'h2c3c0);
    chk("masked lane kept", {24'h0, last_word[7:0]}, 32'h03);
    chk("open lane stored", {24'h0, last_word[15:8]}, 32'hc3);
    crc_en <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    chk("persistent crc", {31'h0, crc_p}, 32'h1);
    cfg(2'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge i_core_clk);
    chk("nonpersistent crc", {31'h0, crc_p}, 32'h0);
    crc_en <= 1'b0;
    $display("test masking done");
    cfg(2'h2, 1'b0, 1'b0, 1'b0);
    burst({2'b01, 4'h3, 4'h4}, 2, 18'h34400);
    chk("fixed chop word", {16'h0, last_word}, 32'h4401);
    cfg(2'h1, 1'b0, 1'b0, 1'b0);
    burst({2'b00, 4'h3, 4'h8}, 2, 18'h35500);
    chk("per command chop", {16'h0, last_word}, 32'h5501);
    burst({2'b01, 4'h3, 4'h8}, 4, 18'h36600);
    chk("per command full", {16'h0, last_word}, 32'h6603);
    $display("test burst modes done");
    cfg(2'h0, 1'b1, 1'b1, 1'b0);
    rd(`SDWB_REG_STATUS);
    chk("mask with inversion", {31'h0, rv[6]}, 32'h1);
    cfg(2'h1, 1'b0, 1'b0, 1'b1);
    wr(`SDWB_REG_TIMING, {10'h0, 6'h04, 6'h06, 5'h09, 5'h00});
    rd(`SDWB_REG_STATUS);
    chk("lowest latency refused", {30'h0, rv[6], 1'b0}, 32'h2);
    chk("status mode", {30'h0, rv[1:0]}, 32'h1);
    wr(`SDWB_REG_TIMING, {10'h0, 6'h04, 6'h06, 5'h0a, 5'h00});
    rd(`SDWB_REG_STATUS);
    chk("raised latency legal", {31'h0, rv[6]}, 32'h0);
    burst({2'b01, 4'h4, 4'h0}, 4, 18'h38800);
    chk("two clock preamble word", {16'h0, last_word}, 32'h8803);
    rd(4'h7);
    $display("test refusals done");
    cfg(2'h0, 1'b0, 1'b0, 1'b0);
    for (k = 0; k < 33; k++)
      wr(`SDWB_REG_DATA, {14'h0, 18'h37000 + 18'(k)});
    rd(`SDWB_REG_STATUS);
    chk("buffer full", {30'h0, rv[4], rv[2]}, 32'h1);
    for (k = 0; k < 8; k++)
      burst({2'b01, 4'h1, 4'h0}, 0, 18'h0);
    rd(`SDWB_REG_STATUS);
    chk("buffer empty", {31'h0, rv[2]}, 32'h0);
    chk("drained last word", {16'h0, last_word}, 32'h701f);
    $display("test buffer done");
    test_done();
  end
endmodule : sdwb_write_burst_control_bench
